// ===== verilog/bdma_core.sv
// Address generation, bank select register and bank gating for banked data memory
// Contract
// - window is bank15 top 160 plus bank0 96
// - access bit picks bank register or window
// - window offsets form one contiguous 256 range
// - sixteen banks of 256 static bytes
// - bank nibble forms address bits 11..8
// - bank register upper nibble reads zero, unwritable
// - unimplemented bank reads zero, drops writes
// - flags still follow zero read data
// - full-address move ignores the bank register
// - load-bank-literal op writes bank register
`timescale 1ns/100ps
module bdma_core (
    input  wire logic                    clock,
    input  wire logic                    rst_b,
    // Execute stage request
    input  wire logic                    op_valid,
    input  wire bdma_pkg::bdma_op_type   op_code,
    input  wire logic                    op_access_sel,
    input  wire logic [7:0]              op_operand,
    input  wire logic [7:0]              op_wdata,
    input  wire logic [11:0]             op_src_addr,
    input  wire logic [11:0]             op_dst_addr,
    output logic                         op_done,
    output logic [7:0]                   op_rdata,
    output logic                         op_zero_flag,
    output logic [11:0]                  op_eff_addr,
    output logic                         op_unimpl,
    // Avalon-MM slave
    input  wire logic [3:0]              avs_address,
    input  wire logic                    avs_read,
    input  wire logic                    avs_write,
    input  wire logic [31:0]             avs_writedata,
    output logic [31:0]                  avs_readdata,
    output logic                         avs_waitrequest
);
    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    typedef struct packed {
        bdma_pkg::bdma_state_type st;
        logic [3:0]   bank;
        logic [15:0]  impl;
        logic [11:0]  move_dst;
        logic         done;
        logic [7:0]   rdata;
        logic         zero;
        logic [11:0]  eff;
        logic         unimpl;
        logic [31:0]  avs_rd;
        logic         avs_ack;
    } bdma_state_s_type;

    bdma_state_s_type s_q;
    bdma_state_s_type s_d;

    logic [11:0] ram_raddr;
    logic [11:0] ram_waddr;
    logic [7:0]  ram_wdata;
    logic        ram_we;
    logic [7:0]  ram_rdata;

    // -------------------------------------------------------------------
    // Address mapping
    // -------------------------------------------------------------------
    function automatic logic [11:0] bdma_map(input logic asel, input logic [3:0] bank,
                                             input logic [7:0] off);
        logic [11:0] a;
        a = {bank, off};
        if (!asel) begin
            // Low window below 0x60, otherwise the peripheral top of bank 15
            if (off <= bdma_pkg::WIN_LOW_LAST) begin
                a = {bdma_pkg::WIN_LO_BANK, off};
            end else begin
                a = {bdma_pkg::WIN_HI_BANK, off};
            end
        end
        return a;
    endfunction

    function automatic logic bdma_impl(input logic [15:0] m, input logic [11:0] a);
        return m[a[11:8]];
    endfunction

    logic [11:0] direct_addr;
    logic        mv_src_ok;
    logic        mv_dst_ok;
    logic        dir_ok;
    logic        avs_req;

    assign direct_addr = bdma_map(op_access_sel, s_q.bank, op_operand);
    assign dir_ok      = bdma_impl(s_q.impl, direct_addr);
    assign mv_src_ok   = bdma_impl(s_q.impl, op_src_addr);
    assign mv_dst_ok   = bdma_impl(s_q.impl, s_q.move_dst);
    // The ack flop masks the request that the master still holds, so one access is taken once
    assign avs_req     = (avs_read || avs_write) && !s_q.avs_ack;

    // -------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------
    always_comb begin
        s_d         = s_q;
        s_d.done    = 1'b0;
        s_d.avs_ack = 1'b0;
        ram_raddr   = direct_addr;
        ram_waddr   = direct_addr;
        ram_wdata   = op_wdata;
        ram_we      = 1'b0;
        unique case (s_q.st)
            bdma_pkg::BDMA_ST_IDLE: begin
                if (op_valid) begin
                    unique case (op_code)
                        bdma_pkg::BDMA_OP_READ: begin
                            s_d.done   = 1'b1;
                            s_d.eff    = direct_addr;
                            s_d.unimpl = !dir_ok;
                            s_d.rdata  = dir_ok ? ram_rdata : 8'h00;
                            s_d.zero   = dir_ok ? (ram_rdata == 8'h00) : 1'b1;
                        end
                        bdma_pkg::BDMA_OP_WRITE: begin
                            s_d.done   = 1'b1;
                            s_d.eff    = direct_addr;
                            s_d.unimpl = !dir_ok;
                            ram_we     = dir_ok;
                            s_d.zero   = (op_wdata == 8'h00);
                        end
                        bdma_pkg::BDMA_OP_LOAD_BANK: begin
                            s_d.done   = 1'b1;
                            s_d.bank   = op_operand[bdma_pkg::BANK_SEL_MASK_W-1:0];
                        end
                        bdma_pkg::BDMA_OP_MOVE_FULL: begin
                            // Source read now, destination written next cycle
                            ram_raddr  = op_src_addr;
                            s_d.rdata  = mv_src_ok ? ram_rdata : 8'h00;
                            s_d.eff    = op_src_addr;
                            s_d.move_dst = op_dst_addr;
                            s_d.st     = bdma_pkg::BDMA_ST_MOVE_WR;
                        end
                        default: begin
                            s_d.done   = 1'b1;
                        end
                    endcase
                end
            end
            bdma_pkg::BDMA_ST_MOVE_WR: begin
                ram_waddr  = s_q.move_dst;
                ram_wdata  = s_q.rdata;
                ram_we     = mv_dst_ok;
                s_d.eff    = s_q.move_dst;
                s_d.unimpl = !mv_dst_ok;
                s_d.done   = 1'b1;
                s_d.st     = bdma_pkg::BDMA_ST_IDLE;
            end
        endcase

        // Bus slave: taken at the first edge, answered at the second
        if (avs_req) begin
            s_d.avs_ack = 1'b1;
            s_d.avs_rd  = 32'h0000_0000;
            if (avs_read) begin
                unique case (avs_address)
                    bdma_pkg::OFF_BANK_SEL:  s_d.avs_rd = {28'h000_0000, s_q.bank};
                    bdma_pkg::OFF_STATUS:    s_d.avs_rd = {19'h0, s_q.unimpl, s_q.eff};
                    bdma_pkg::OFF_IMPL_MASK: s_d.avs_rd = {16'h0000, s_q.impl};
                    default:                 s_d.avs_rd = 32'h0000_0000;
                endcase
            end
        end
        // A write lands at the answer edge, the one at which the master sees waitrequest low
        if (s_q.avs_ack && avs_write) begin
            // A load-bank op in the same cycle wins over the bus write
            if (avs_address == bdma_pkg::OFF_BANK_SEL &&
                !(s_q.st == bdma_pkg::BDMA_ST_IDLE && op_valid &&
                  op_code == bdma_pkg::BDMA_OP_LOAD_BANK)) begin
                s_d.bank = avs_writedata[3:0];
            end
            if (avs_address == bdma_pkg::OFF_IMPL_MASK) begin
                s_d.impl = avs_writedata[15:0];
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_q        <= '0;
            s_q.st     <= bdma_pkg::BDMA_ST_IDLE;
            s_q.bank   <= bdma_pkg::BANK_SEL_RST[3:0];
            s_q.impl   <= bdma_pkg::IMPL_MASK_RST;
        end else begin
            s_q <= s_d;
        end
    end

    bdma_ram #(
        .AW (bdma_pkg::ADDR_W)
    ) i_bdma_ram (
        .clock (clock),
        .we    (ram_we),
        .waddr (ram_waddr),
        .wdata (ram_wdata),
        .raddr (ram_raddr),
        .rdata (ram_rdata)
    );

    assign op_done         = s_q.done;
    assign op_rdata        = s_q.rdata;
    assign op_zero_flag    = s_q.zero;
    assign op_eff_addr     = s_q.eff;
    assign op_unimpl       = s_q.unimpl;
    assign avs_readdata    = s_q.avs_rd;
    assign avs_waitrequest = !s_q.avs_ack;

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    a_window_low_map: assert property (op_valid && s_q.st == bdma_pkg::BDMA_ST_IDLE &&
        op_code == bdma_pkg::BDMA_OP_READ && !op_access_sel && op_operand <= 8'h5f
        |=> op_eff_addr[11:8] == 4'h0)
        else $error("low window offset not in bank 0");
    a_window_high_map: assert property (op_valid && s_q.st == bdma_pkg::BDMA_ST_IDLE &&
        op_code == bdma_pkg::BDMA_OP_READ && !op_access_sel && op_operand > 8'h5f
        |=> op_eff_addr[11:8] == 4'hf && op_eff_addr[7:0] == $past(op_operand))
        else $error("high window offset not in bank 15");
    a_banked_addr: assert property (op_valid && s_q.st == bdma_pkg::BDMA_ST_IDLE &&
        op_code == bdma_pkg::BDMA_OP_READ && op_access_sel
        |=> op_eff_addr == {$past(s_q.bank), $past(op_operand)})
        else $error("banked address wrong");
    a_bank_upper_zero: assert property (!avs_waitrequest && $past(avs_read) &&
        $past(avs_address) == bdma_pkg::OFF_BANK_SEL |-> avs_readdata[31:4] == 28'h0)
        else $error("bank register upper bits not zero");
    a_unimpl_read_zero: assert property (op_done && op_unimpl &&
        $past(op_code) == bdma_pkg::BDMA_OP_READ && $past(s_q.st) == bdma_pkg::BDMA_ST_IDLE
        |-> op_rdata == 8'h00)
        else $error("unimplemented bank returned data");
    a_unimpl_no_write: assert property (ram_we |-> bdma_impl(s_q.impl, ram_waddr))
        else $error("write reached unimplemented bank");
    a_zero_flag_set: assert property (op_done && $past(op_code) == bdma_pkg::BDMA_OP_READ
        && $past(s_q.st) == bdma_pkg::BDMA_ST_IDLE |-> op_zero_flag == (op_rdata == 8'h00))
        else $error("zero flag does not follow read data");
    a_load_bank: assert property (op_valid && s_q.st == bdma_pkg::BDMA_ST_IDLE &&
        op_code == bdma_pkg::BDMA_OP_LOAD_BANK |=> s_q.bank == $past(op_operand[3:0]))
        else $error("load bank literal not taken");
    a_move_dest: assert property (op_valid && s_q.st == bdma_pkg::BDMA_ST_IDLE &&
        op_code == bdma_pkg::BDMA_OP_MOVE_FULL |=> ##1 op_done && op_eff_addr == $past(op_dst_addr, 2))
        else $error("full move destination wrong");
    a_move_source: assert property (op_valid && s_q.st == bdma_pkg::BDMA_ST_IDLE &&
        op_code == bdma_pkg::BDMA_OP_MOVE_FULL
        |=> s_q.st == bdma_pkg::BDMA_ST_MOVE_WR && op_eff_addr == $past(op_src_addr))
        else $error("full move source wrong");
    a_move_src_zero: assert property (op_valid && s_q.st == bdma_pkg::BDMA_ST_IDLE &&
        op_code == bdma_pkg::BDMA_OP_MOVE_FULL && !mv_src_ok |=> op_rdata == 8'h00)
        else $error("full move read data from unimplemented bank");
    a_write_zero_flag: assert property (op_done && $past(op_code) == bdma_pkg::BDMA_OP_WRITE
        && $past(s_q.st) == bdma_pkg::BDMA_ST_IDLE
        |-> op_zero_flag == ($past(op_wdata) == 8'h00))
        else $error("zero flag does not follow write data");
    a_unimpl_read_flag: assert property (op_done && op_unimpl &&
        $past(op_code) == bdma_pkg::BDMA_OP_READ && $past(s_q.st) == bdma_pkg::BDMA_ST_IDLE
        |-> op_zero_flag)
        else $error("zero flag clear after unimplemented read");
    a_window_span: assert property (op_valid && s_q.st == bdma_pkg::BDMA_ST_IDLE &&
        !op_access_sel && (op_code == bdma_pkg::BDMA_OP_READ || op_code == bdma_pkg::BDMA_OP_WRITE)
        |=> (op_eff_addr[11:8] == bdma_pkg::WIN_LO_BANK && op_eff_addr[7:0] < bdma_pkg::WIN_LO_BYTES) ||
            (op_eff_addr[11:8] == bdma_pkg::WIN_HI_BANK &&
             op_eff_addr[7:0] >= bdma_pkg::BANK_BYTES - bdma_pkg::WIN_HI_BYTES))
        else $error("window address outside both window parts");
    a_write_banked: assert property (op_valid && s_q.st == bdma_pkg::BDMA_ST_IDLE &&
        op_code == bdma_pkg::BDMA_OP_WRITE && op_access_sel
        |=> op_eff_addr == {$past(s_q.bank), $past(op_operand)})
        else $error("banked write address wrong");
    // Done marks the edge at which the results of an op become valid
    a_read_done: assert property (op_valid && s_q.st == bdma_pkg::BDMA_ST_IDLE &&
        op_code == bdma_pkg::BDMA_OP_READ |=> op_done)
        else $error("read not finished in one cycle");
    a_move_two_cycles: assert property (op_valid && s_q.st == bdma_pkg::BDMA_ST_IDLE &&
        op_code == bdma_pkg::BDMA_OP_MOVE_FULL |=> !op_done)
        else $error("full move finished too early");

    // -------------------------------------------------------------------
    // Bus checks
    // -------------------------------------------------------------------
    a_bus_answer: assert property (avs_read && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
        else $error("bus answer late");
    // A bus write that loses to a load-bank op is left to a_load_bank
    a_bank_write: assert property (s_q.avs_ack && avs_write &&
        avs_address == bdma_pkg::OFF_BANK_SEL &&
        !(op_valid && s_q.st == bdma_pkg::BDMA_ST_IDLE && op_code == bdma_pkg::BDMA_OP_LOAD_BANK)
        |=> s_q.bank == $past(avs_writedata[3:0]))
        else $error("bank register write not taken");
    // Waitrequest drops only for the one answer cycle of a request
    a_wait_idle: assert property (!avs_read && !avs_write && !$past(avs_read) && !$past(avs_write)
        |-> avs_waitrequest)
        else $error("waitrequest low without a request");

    c_window_read: cover property (op_valid && op_code == bdma_pkg::BDMA_OP_READ && !op_access_sel);
    c_unimpl_read: cover property (op_done && op_unimpl);
    c_move_full:   cover property (s_q.st == bdma_pkg::BDMA_ST_MOVE_WR);
    c_bus_write:   cover property (avs_write && !avs_waitrequest);
    c_load_bank:   cover property (op_valid && s_q.st == bdma_pkg::BDMA_ST_IDLE &&
        op_code == bdma_pkg::BDMA_OP_LOAD_BANK);
endmodule

// ===== verilog/bdma_pkg.sv
// Package of constants and types for the banked data memory addressing block
package bdma_pkg;
    // -------------------------------------------------------------------
    // Memory geometry
    // -------------------------------------------------------------------
    localparam int unsigned ADDR_W       = 12;
    localparam int unsigned BANK_W       = 4;
    localparam int unsigned NUM_BANKS    = 16;
    localparam int unsigned BANK_BYTES   = 256;
    localparam logic [7:0]  WIN_LOW_LAST = 8'h5f;
    localparam logic [3:0]  WIN_HI_BANK  = 4'hf;
    localparam logic [3:0]  WIN_LO_BANK  = 4'h0;
    localparam int unsigned WIN_HI_BYTES = 160;
    localparam int unsigned WIN_LO_BYTES = 96;

    // -------------------------------------------------------------------
    // Register map, byte addresses on the bus
    // -------------------------------------------------------------------
    localparam logic [3:0] OFF_BANK_SEL  = 4'h0;
    localparam logic [3:0] OFF_STATUS    = 4'h4;
    localparam logic [3:0] OFF_IMPL_MASK = 4'h8;
    localparam logic [7:0] BANK_SEL_RST  = 8'h00;
    localparam logic [15:0] IMPL_MASK_RST = 16'hffff;
    localparam int unsigned BANK_SEL_MASK_W = 4;

    // -------------------------------------------------------------------
    // Operations issued by the execute stage
    // -------------------------------------------------------------------
    typedef enum logic [2:0] {
        BDMA_OP_NONE,
        BDMA_OP_READ,
        BDMA_OP_WRITE,
        BDMA_OP_LOAD_BANK,
        BDMA_OP_MOVE_FULL
    } bdma_op_type;

    typedef enum logic [1:0] {
        BDMA_ST_IDLE,
        BDMA_ST_MOVE_WR
    } bdma_state_type;
endpackage

// ===== verilog/bdma_ram.sv
// Byte-wide static storage for the banked data memory
`timescale 1ns/100ps
module bdma_ram #(
    parameter int unsigned AW = 12
) (
    input  wire logic          clock,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [7:0]    wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [7:0]    rdata
);
    logic [7:0] mem_q [0:(1<<AW)-1];

    // No reset on storage: it is plain static RAM, contents undefined at start
    always_ff @(posedge clock) begin
        if (we) begin
            mem_q[waddr] <= wdata;
        end
    end

    assign rdata = mem_q[raddr];
endmodule

// ===== dv/bdma_exec_model.sv
// Execute-stage model that issues memory operations to the addressing block
`timescale 1ns/100ps
module bdma_exec_model (
    input  wire logic             clock,
    output logic                  op_valid,
    output bdma_pkg::bdma_op_type op_code,
    output logic                  op_access_sel,
    output logic [7:0]            op_operand,
    output logic [7:0]            op_wdata,
    output logic [11:0]           op_src_addr,
    output logic [11:0]           op_dst_addr,
    input  wire logic             op_done,
    input  wire logic [7:0]       op_rdata,
    input  wire logic             op_zero_flag,
    input  wire logic [11:0]      op_eff_addr,
    input  wire logic             op_unimpl
);
    logic [7:0]  res_rdata;
    logic        res_zero;
    logic [11:0] res_eff;
    logic        res_unimpl;
    int          late;

    initial begin
        op_valid      = 1'b0;
        op_code       = bdma_pkg::BDMA_OP_NONE;
        op_access_sel = 1'b0;
        op_operand    = 8'h00;
        op_wdata      = 8'h00;
        op_src_addr   = 12'h000;
        op_dst_addr   = 12'h000;
        late          = 0;
    end

    // Gap idles before the request, so the stage can be prompt or slow
    task automatic issue(input bdma_pkg::bdma_op_type code, input logic sel, input logic [7:0] opnd,
                         input logic [7:0] wd, input logic [11:0] src, input logic [11:0] dst, input int gap);
        int n;
        n = 0;
        repeat (gap + 1) @(posedge clock);
        op_valid      <= 1'b1;
        op_code       <= code;
        op_access_sel <= sel;
        op_operand    <= opnd;
        op_wdata      <= wd;
        op_src_addr   <= src;
        op_dst_addr   <= dst;
        @(posedge clock);
        // Fields flip once taken, so a design that re-reads them is caught
        op_valid      <= 1'b0;
        op_code       <= bdma_pkg::BDMA_OP_NONE;
        op_access_sel <= ~sel;
        op_operand    <= ~opnd;
        op_wdata      <= ~wd;
        op_src_addr   <= ~src;
        op_dst_addr   <= ~dst;
        // Results are taken at the rising edge that shows done, as a register of the stage would
        do begin
            @(posedge clock);
            n++;
        end while (op_done !== 1'b1 && n < 8);
        if (n >= 8) late++;
        res_rdata  = op_rdata;
        res_zero   = op_zero_flag;
        res_eff    = op_eff_addr;
        res_unimpl = op_unimpl;
        @(posedge clock);
    endtask
endmodule

// ===== dv/bdma_core_tb.sv
// Self-checking bench for the banked data memory addressing block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin errors++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module bdma_core_tb;
    logic                  clock;
    logic                  rst_b;
    logic                  op_valid;
    bdma_pkg::bdma_op_type op_code;
    logic                  op_access_sel;
    logic [7:0]            op_operand;
    logic [7:0]            op_wdata;
    logic [11:0]           op_src_addr;
    logic [11:0]           op_dst_addr;
    logic                  op_done;
    logic [7:0]            op_rdata;
    logic                  op_zero_flag;
    logic [11:0]           op_eff_addr;
    logic                  op_unimpl;
    logic [3:0]            avs_address;
    logic                  avs_read;
    logic                  avs_write;
    logic [31:0]           avs_writedata;
    logic [31:0]           avs_readdata;
    logic                  avs_waitrequest;
    logic [31:0]           rd;
    int                    errors;
    int                    checked;
    logic [7:0]            wo [3] = '{8'h00, 8'h5f, 8'hff};
    logic [11:0]           wa [3] = '{12'h000, 12'h05f, 12'hfff};

    bdma_core i_bdma_core (.clock(clock), .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code),
        .op_access_sel(op_access_sel), .op_operand(op_operand), .op_wdata(op_wdata), .op_src_addr(op_src_addr),
        .op_dst_addr(op_dst_addr), .op_done(op_done), .op_rdata(op_rdata), .op_zero_flag(op_zero_flag),
        .op_eff_addr(op_eff_addr), .op_unimpl(op_unimpl), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));

    bdma_exec_model i_bdma_exec_model (.clock(clock), .op_valid(op_valid), .op_code(op_code),
        .op_access_sel(op_access_sel), .op_operand(op_operand), .op_wdata(op_wdata), .op_src_addr(op_src_addr),
        .op_dst_addr(op_dst_addr), .op_done(op_done), .op_rdata(op_rdata), .op_zero_flag(op_zero_flag),
        .op_eff_addr(op_eff_addr), .op_unimpl(op_unimpl));

    always #50 clock = ~clock;

    // ----------------------------------------------------------------
    // Access tasks
    // ----------------------------------------------------------------
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clock);
        avs_address   <= a;
        avs_read      <= ~wr;
        avs_write     <= wr;
        avs_writedata <= d;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) errors++;
        q = avs_readdata;
        avs_read      <= 1'b0;
        avs_write     <= 1'b0;
        avs_address   <= ~a;
        avs_writedata <= ~d;
    endtask

    task automatic op(input bdma_pkg::bdma_op_type c, input logic s, input logic [7:0] o, input logic [7:0] w);
        i_bdma_exec_model.issue(c, s, o, w, 12'h000, 12'h000, 0);
    endtask

    task automatic chk_rd(input logic [7:0] e, input logic [11:0] ea, input logic eu);
        `CHK("rdata", e, i_bdma_exec_model.res_rdata)
        `CHK("zero", (e == 8'h00), i_bdma_exec_model.res_zero)
        `CHK("eff_addr", ea, i_bdma_exec_model.res_eff)
        `CHK("unimpl", eu, i_bdma_exec_model.res_unimpl)
    endtask

    task automatic summarize;
        $display("Checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        clock = 1'b0; rst_b = 1'b0; errors = 0; checked = 0;
        avs_address = 4'h0; avs_read = 1'b0; avs_write = 1'b0; avs_writedata = 32'h0;
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        bus(1'b0, bdma_pkg::OFF_BANK_SEL, 32'h0, rd);
        `CHK("bank_sel reset", {24'h0, bdma_pkg::BANK_SEL_RST}, rd)
        bus(1'b0, bdma_pkg::OFF_IMPL_MASK, 32'h0, rd);
        `CHK("mask reset", {16'h0, bdma_pkg::IMPL_MASK_RST}, rd)
        bus(1'b0, 4'hc, 32'h0, rd);
        `CHK("unmapped", 32'h0, rd)
        bus(1'b1, bdma_pkg::OFF_BANK_SEL, 32'h0000_00ff, rd);
        bus(1'b0, bdma_pkg::OFF_BANK_SEL, 32'h0, rd);
        `CHK("bank_sel upper", 32'h0000_000f, rd)
        op(bdma_pkg::BDMA_OP_LOAD_BANK, 1'b0, 8'ha5, 8'h00);
        bus(1'b0, bdma_pkg::OFF_BANK_SEL, 32'h0, rd);
        `CHK("load bank", 32'h0000_0005, rd)
        // Same offset in every bank: any aliasing between banks shows on read back
        for (int b = 0; b < 16; b++) begin
            op(bdma_pkg::BDMA_OP_LOAD_BANK, 1'b0, 8'(b), 8'h00);
            op(bdma_pkg::BDMA_OP_WRITE, 1'b1, 8'h10, 8'(8'h30 + b));
            `CHK("bank eff", {4'(b), 8'h10}, i_bdma_exec_model.res_eff)
        end
        for (int b = 0; b < 16; b++) begin
            op(bdma_pkg::BDMA_OP_LOAD_BANK, 1'b0, 8'(b), 8'h00);
            op(bdma_pkg::BDMA_OP_READ, 1'b1, 8'h10, 8'h00);
            chk_rd(8'(8'h30 + b), {4'(b), 8'h10}, 1'b0);
        end
        op(bdma_pkg::BDMA_OP_WRITE, 1'b0, 8'h60, 8'h77);
        `CHK("window high", 12'hf60, i_bdma_exec_model.res_eff)
        op(bdma_pkg::BDMA_OP_READ, 1'b0, 8'h10, 8'h00);
        chk_rd(8'h30, 12'h010, 1'b0);
        // Window ends are written first so their reads return known data; i = 0 writes a zero
        for (int i = 0; i < 3; i++) begin
            op(bdma_pkg::BDMA_OP_WRITE, 1'b0, wo[i], 8'(8'h40 * i));
            `CHK("write zero", (i == 0), i_bdma_exec_model.res_zero)
            op(bdma_pkg::BDMA_OP_READ, 1'b0, wo[i], 8'h00);
            `CHK("window eff", wa[i], i_bdma_exec_model.res_eff)
            chk_rd(8'(8'h40 * i), wa[i], 1'b0);
        end
        op(bdma_pkg::BDMA_OP_READ, 1'b1, 8'h60, 8'h00);
        chk_rd(8'h77, 12'hf60, 1'b0);
        op(bdma_pkg::BDMA_OP_LOAD_BANK, 1'b0, 8'h07, 8'h00);
        i_bdma_exec_model.issue(bdma_pkg::BDMA_OP_MOVE_FULL, 1'b1, 8'h00, 8'h00, 12'h210, 12'h3a0, 3);
        bus(1'b0, bdma_pkg::OFF_BANK_SEL, 32'h0, rd);
        `CHK("bank after move", 32'h0000_0007, rd)
        op(bdma_pkg::BDMA_OP_LOAD_BANK, 1'b0, 8'h03, 8'h00);
        op(bdma_pkg::BDMA_OP_READ, 1'b1, 8'ha0, 8'h00);
        chk_rd(8'h32, 12'h3a0, 1'b0);
        bus(1'b1, bdma_pkg::OFF_IMPL_MASK, 32'h0000_ffdf, rd);
        op(bdma_pkg::BDMA_OP_LOAD_BANK, 1'b0, 8'h05, 8'h00);
        op(bdma_pkg::BDMA_OP_WRITE, 1'b1, 8'h10, 8'h99);
        `CHK("unimpl write", 1'b1, i_bdma_exec_model.res_unimpl)
        `CHK("unimpl write zero", 1'b0, i_bdma_exec_model.res_zero)
        op(bdma_pkg::BDMA_OP_READ, 1'b1, 8'h10, 8'h00);
        chk_rd(8'h00, 12'h510, 1'b1);
        bus(1'b0, bdma_pkg::OFF_STATUS, 32'h0, rd);
        `CHK("status", 32'h0000_1510, rd)
        // A full move out of the missing bank carries zero into a present one
        i_bdma_exec_model.issue(bdma_pkg::BDMA_OP_MOVE_FULL, 1'b0, 8'h00, 8'h00, 12'h510, 12'h3a0, 0);
        op(bdma_pkg::BDMA_OP_LOAD_BANK, 1'b0, 8'h03, 8'h00);
        op(bdma_pkg::BDMA_OP_READ, 1'b1, 8'ha0, 8'h00);
        chk_rd(8'h00, 12'h3a0, 1'b0);
        bus(1'b1, bdma_pkg::OFF_IMPL_MASK, 32'h0000_ffff, rd);
        op(bdma_pkg::BDMA_OP_LOAD_BANK, 1'b0, 8'h05, 8'h00);
        op(bdma_pkg::BDMA_OP_READ, 1'b1, 8'h10, 8'h00);
        chk_rd(8'h35, 12'h510, 1'b0);
        `CHK("op timeouts", 0, i_bdma_exec_model.late)
        summarize();
    end

    initial begin
        repeat (3000) @(posedge clock);
        errors++;
        summarize();
    end
endmodule
